//--- osc_clock_ctrl.sv
// Oscillator watch, regulator control and peripheral clock gating
`timescale 1ns/1ps
`default_nettype none

module osc_watch #(
   parameter int WIN = 16
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic active,
   input  wire logic mon_lvl,
   input  wire logic ref_lvl,
   output logic      fail
);
   localparam int CW = $clog2(WIN + 1);
   logic          mon_q, mon_d, ref_q, ref_d;
   logic [CW-1:0] cnt_q, cnt_d;

   if (WIN < 2)
   begin : g_win_chk
      $error("osc_watch window must be at least 2");
   end

   // Count reference rises since the last monitored edge
   always_comb
   begin
      mon_d = mon_lvl;
      ref_d = ref_lvl;
      cnt_d = cnt_q;
      fail  = 1'b0;
      if (!active || mon_lvl != mon_q)
         cnt_d = '0;
      else if (ref_lvl && !ref_q)
      begin
         if (cnt_q == CW'(WIN - 1))
         begin
            fail  = 1'b1;
            cnt_d = '0;
         end
         else
            cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mon_q <= 1'b0;
         ref_q <= 1'b0;
         cnt_q <= '0;
      end
      else
      begin
         mon_q <= mon_d;
         ref_q <= ref_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

module osc_clock_ctrl
#(
   parameter int NPERIPH = osc_ctl_pkg::NPERIPH_DFLT,
   parameter int OSC_WIN = osc_ctl_pkg::OSC_WIN_DFLT
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               main_oscillator,
   input  wire logic               internal_osc,
   input  wire logic               main_osc_on,
   input  wire logic               int_osc_on,
   input  wire logic               reg_unregulated,
   input  wire logic               sleep_mode,
   input  wire logic               deep_sleep_mode,
   output logic [NPERIPH-1:0]      periph_clk_en,
   output logic [osc_ctl_pkg::REGV_W-1:0] core_regulator_sel,
   output logic                    reg_fail_rst,
   output logic                    irq
);
   import osc_ctl_pkg::*;

   if (NPERIPH < 1 || NPERIPH > 32)
   begin : g_nperiph_chk
      $error("NPERIPH must be 1..32");
   end

   // Bus channel state
   logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   // Register state
   ctrl_t              ctrl_q, ctrl_d;
   logic [REGV_W-1:0]  regv_q, regv_d;
   logic [NPERIPH-1:0] run_q, run_d, slp_q, slp_d, dslp_q, dslp_d;
   logic [NPERIPH-1:0] clk_q, clk_d;
   irq_t               stat_q, stat_d, mask_q, mask_d, ev, clr;
   logic               rst_q, rst_d;
   logic               both_on, int_act, main_act, int_fail, main_fail;
   logic               do_wr, do_rd;
   logic [31:0]        bm, wv, rv;
   logic [7:0]         ra;
   logic               rhit, whit;

   // Oscillator watches, each needs both oscillators running
   assign both_on  = main_osc_on && int_osc_on;
   assign int_act  = ctrl_q.int_verify_en && both_on;
   assign main_act = (ctrl_q.main_verify_en ||
                      ctrl_q.main_osc_check_enable) && both_on;

   osc_watch #(.WIN(OSC_WIN)) u_int_watch (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .active  (int_act),
      .mon_lvl (internal_osc),
      .ref_lvl (main_oscillator),
      .fail    (int_fail)
   );

   osc_watch #(.WIN(OSC_WIN)) u_main_watch (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .active  (main_act),
      .mon_lvl (main_oscillator),
      .ref_lvl (internal_osc),
      .fail    (main_fail)
   );

   assign do_wr = aw_q && w_q && !b_q;
   assign do_rd = s_axi_arvalid && !r_q;
   assign s_axi_awready = !aw_q && !b_q;
   assign s_axi_wready  = !w_q && !b_q;
   assign s_axi_arready = !r_q;
   assign s_axi_bvalid  = b_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_rvalid  = r_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   assign ra = {s_axi_araddr[7:2], 2'b00};

   always_comb
   begin
      bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
      rv = '0;
      rhit = 1'b1;
      case (ra)
         OFF_CTRL: rv[4:0] = ctrl_q;
         OFF_REGV: rv[REGV_W-1:0] = regv_q;
         OFF_RUN:  rv[NPERIPH-1:0] = run_q;
         OFF_SLP:  rv[NPERIPH-1:0] = slp_q;
         OFF_DSLP: rv[NPERIPH-1:0] = dslp_q;
         OFF_STAT: rv[1:0] = stat_q;
         OFF_MASK: rv[1:0] = mask_q;
         OFF_LIVE: rv[5:0] = {deep_sleep_mode, sleep_mode, rst_q,
                              main_act, int_act, both_on};
         default:  rhit = 1'b0;
      endcase
      case ({awa_q[7:2], 2'b00})
         OFF_CTRL, OFF_REGV, OFF_RUN, OFF_SLP, OFF_DSLP,
         OFF_STAT, OFF_MASK, OFF_LIVE: whit = 1'b1;
         default: whit = 1'b0;
      endcase
   end

   // Bus handshake
   always_comb
   begin
      aw_d  = aw_q;
      w_d   = w_q;
      b_d   = b_q;
      r_d   = r_q;
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      br_d  = br_q;
      rd_d  = rd_q;
      rr_d  = rr_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (do_wr)
      begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         b_d  = 1'b1;
         br_d = whit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_q && s_axi_bready)
         b_d = 1'b0;
      if (do_rd)
      begin
         r_d  = 1'b1;
         rd_d = rv;
         rr_d = rhit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_q && s_axi_rready)
         r_d = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         b_q   <= 1'b0;
         r_q   <= 1'b0;
         awa_q <= '0;
         wd_q  <= '0;
         ws_q  <= '0;
         br_q  <= RESP_OKAY;
         rd_q  <= '0;
         rr_q  <= RESP_OKAY;
      end
      else
      begin
         aw_q  <= aw_d;
         w_q   <= w_d;
         b_q   <= b_d;
         r_q   <= r_d;
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         br_q  <= br_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
      end
   end

   // Registers, status, gating
   always_comb
   begin
      wv     = (wd_q & bm);
      ctrl_d = ctrl_q;
      regv_d = regv_q;
      run_d  = run_q;
      slp_d  = slp_q;
      dslp_d = dslp_q;
      mask_d = mask_q;
      clr    = '0;
      if (do_wr)
      begin
         case ({awa_q[7:2], 2'b00})
            OFF_CTRL: ctrl_d = ctrl_t'((ctrl_q & ~bm[4:0]) | wv[4:0]);
            OFF_REGV:
               if (ws_q[0] && wd_q[REGV_W-1:0] <= REGV_MAX)
                  regv_d = wd_q[REGV_W-1:0];
            OFF_RUN:  run_d = (run_q & ~bm[NPERIPH-1:0]) | wv[NPERIPH-1:0];
            OFF_SLP:  slp_d = (slp_q & ~bm[NPERIPH-1:0]) | wv[NPERIPH-1:0];
            OFF_DSLP:
               dslp_d = (dslp_q & ~bm[NPERIPH-1:0]) | wv[NPERIPH-1:0];
            OFF_STAT: clr = irq_t'(wv[1:0]);
            OFF_MASK: mask_d = irq_t'((mask_q & ~bm[1:0]) | wv[1:0]);
            default: ;
         endcase
      end
      if (do_rd && ra == OFF_STAT)
         clr = clr | stat_q;
      ev.internal_osc_fail_irq = int_fail;
      ev.main_osc_fail_irq     = main_fail;
      stat_d = (stat_q & ~clr) | ev;
      rst_d  = ctrl_q.regulator_fail_reset && reg_unregulated;
      // Deep-sleep bits only matter with gating on
      if (!ctrl_q.gate_en)
         clk_d = run_q;
      else if (deep_sleep_mode)
         clk_d = run_q & dslp_q;
      else if (sleep_mode)
         clk_d = run_q & slp_q;
      else
         clk_d = run_q;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_q <= CTRL_RST;
         regv_q <= REGV_RST;
         run_q  <= '0;
         slp_q  <= '0;
         dslp_q <= '0;
         mask_q <= IRQ_RST;
         stat_q <= IRQ_RST;
         rst_q  <= 1'b0;
         clk_q  <= '0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         regv_q <= regv_d;
         run_q  <= run_d;
         slp_q  <= slp_d;
         dslp_q <= dslp_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         rst_q  <= rst_d;
         clk_q  <= clk_d;
      end
   end

   assign periph_clk_en      = clk_q;
   assign core_regulator_sel = regv_q;
   assign reg_fail_rst       = rst_q;
   assign irq                = |(stat_q & mask_q);

   property p_int_irq;
      @(posedge clk_sys) disable iff (!rst_b)
      int_fail |=> stat_q.internal_osc_fail_irq;
   endproperty
   a_int_irq: assert property (p_int_irq)
      else $error("internal oscillator failure not latched");

   property p_int_gate;
      @(posedge clk_sys) disable iff (!rst_b)
      !(main_osc_on && int_osc_on && ctrl_q.int_verify_en) |-> !int_fail;
   endproperty
   a_int_gate: assert property (p_int_gate)
      else $error("internal check ran without both oscillators");

   property p_main_irq;
      @(posedge clk_sys) disable iff (!rst_b)
      main_fail |=> stat_q.main_osc_fail_irq;
   endproperty
   a_main_irq: assert property (p_main_irq)
      else $error("main oscillator failure not latched");

   property p_main_gate;
      @(posedge clk_sys) disable iff (!rst_b)
      !(main_osc_on && int_osc_on) |-> !main_fail;
   endproperty
   a_main_gate: assert property (p_main_gate)
      else $error("main check ran without both oscillators");

   property p_reg_rst;
      @(posedge clk_sys) disable iff (!rst_b)
      reg_unregulated |=>
         reg_fail_rst == $past(ctrl_q.regulator_fail_reset);
   endproperty
   a_reg_rst: assert property (p_reg_rst)
      else $error("regulator failure reset wrong");

   property p_regv_range;
      @(posedge clk_sys) disable iff (!rst_b)
      core_regulator_sel <= REGV_MAX;
   endproperty
   a_regv_range: assert property (p_regv_range)
      else $error("regulator setting out of range");

   property p_no_gate;
      @(posedge clk_sys) disable iff (!rst_b)
      !ctrl_q.gate_en |=> periph_clk_en == $past(run_q);
   endproperty
   a_no_gate: assert property (p_no_gate)
      else $error("clock gated while gating disabled");

   property p_deep;
      @(posedge clk_sys) disable iff (!rst_b)
      ctrl_q.gate_en && deep_sleep_mode |=>
         (periph_clk_en & ~$past(dslp_q)) == '0;
   endproperty
   a_deep: assert property (p_deep)
      else $error("clock running in deep-sleep while disabled");

   property p_disabled;
      @(posedge clk_sys) disable iff (!rst_b)
      ##1 (periph_clk_en & ~$past(run_q)) == '0;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled peripheral clocked");

   property p_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      stat_q.main_osc_fail_irq && !do_wr && !do_rd |=>
         stat_q.main_osc_fail_irq;
   endproperty
   a_hold: assert property (p_hold)
      else $error("status bit dropped without a clear");
endmodule

`default_nettype wire

//--- osc_ctl_pkg.sv
// Constants and types shared by the oscillator monitor and clock control
package osc_ctl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_REGV = 8'h04;
   localparam logic [7:0] OFF_RUN  = 8'h08;
   localparam logic [7:0] OFF_SLP  = 8'h0c;
   localparam logic [7:0] OFF_DSLP = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_MASK = 8'h18;
   localparam logic [7:0] OFF_LIVE = 8'h1c;

   // Control register, bits 4..0
   typedef struct packed {
      logic regulator_fail_reset;
      logic main_osc_check_enable;
      logic main_verify_en;
      logic int_verify_en;
      logic gate_en;
   } ctrl_t;
   localparam ctrl_t CTRL_RST = '0;

   // Regulator setting: code 0 is 2.25 V, 0.05 V per step
   localparam int          REGV_W   = 4;
   localparam logic [3:0]  REGV_RST = 4'h5;
   localparam logic [3:0]  REGV_MAX = 4'ha;

   // Interrupt status and mask layout, bits 1..0
   typedef struct packed {
      logic main_osc_fail_irq;
      logic internal_osc_fail_irq;
   } irq_t;
   localparam irq_t IRQ_RST = '0;

   localparam int OSC_WIN_DFLT = 16;
   localparam int NPERIPH_DFLT = 32;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- osc_monitor_sleep_clock_gating_test.sv
// Self-checking testbench for oscillator watch and clock gating control
`timescale 1ns/1ps
`default_nettype none

module osc_monitor_sleep_clock_gating_test;
   import osc_ctl_pkg::*;

   localparam int WIN = 4;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        main_oscillator = 1'b0, internal_osc = 1'b0;
   logic        main_osc_on = 1'b1, int_osc_on = 1'b1;
   logic        reg_unregulated = 1'b0;
   logic        sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
   logic [31:0] periph_clk_en;
   logic [3:0]  core_regulator_sel;
   logic        reg_fail_rst, irq;
   logic        m_run = 1'b1, i_run = 1'b1;
   logic [1:0]  ph = 2'h0;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic [31:0] v;
   logic [1:0]  r;

   osc_clock_ctrl #(.NPERIPH(32), .OSC_WIN(WIN)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .main_oscillator(main_oscillator), .internal_osc(internal_osc),
      .main_osc_on(main_osc_on), .int_osc_on(int_osc_on),
      .reg_unregulated(reg_unregulated), .sleep_mode(sleep_mode),
      .deep_sleep_mode(deep_sleep_mode), .periph_clk_en(periph_clk_en),
      .core_regulator_sel(core_regulator_sel),
      .reg_fail_rst(reg_fail_rst), .irq(irq));

   always #20 clk_sys = ~clk_sys;

   // Oscillators toggle every second cycle while running
   always @(posedge clk_sys)
   begin
      ph <= ph + 2'h1;
      if (ph[0])
      begin
         if (m_run) main_oscillator <= ~main_oscillator;
         if (i_run) internal_osc <= ~internal_osc;
      end
   end

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Handshakes are judged at the negedge before the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] rs);
      int  i;
      logic ta, tw, tb;
      @(posedge clk_sys);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb)
         begin
            bready <= 1'b0;
            break;
         end
      end
      if (i == 50)
      begin
         error_cnt++;
         conclude();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
      int  i;
      logic ta, tr;
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
         if (tr)
         begin
            rready <= 1'b0;
            break;
         end
      end
      if (i == 50)
      begin
         error_cnt++;
         conclude();
      end
   endtask

   task automatic mode(input logic s, input logic d, input logic [31:0] e);
      @(posedge clk_sys);
      sleep_mode <= s;
      deep_sleep_mode <= d;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(periph_clk_en, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(negedge clk_sys);
      chk(periph_clk_en, 32'h0);
      chk(core_regulator_sel, 32'h5);
      for (int a = 0; a <= 8'h1c; a += 4)
      begin
         rd(a[7:0], v, r);
         chk(v, (a == OFF_REGV) ? 32'h5 :
                (a == OFF_LIVE) ? 32'h1 : 32'h0);
      end
      wr(OFF_REGV, 32'ha, r);
      rd(OFF_REGV, v, r);
      chk(v, 32'ha);
      chk(core_regulator_sel, 32'ha);
      wr(OFF_REGV, 32'hb, r);
      chk(r, RESP_OKAY);
      rd(OFF_REGV, v, r);
      chk(v, 32'ha);
      wr(OFF_REGV, 32'h0, r);
      chk(core_regulator_sel, 32'h0);
      wr(8'h20, 32'h1, r);
      chk(r, RESP_SLVERR);
      rd(8'h20, v, r);
      chk(v, 32'h0);
      chk(r, RESP_SLVERR);
      // Clock gating
      wr(OFF_RUN, 32'hf0, r);
      wr(OFF_SLP, 32'h30, r);
      wr(OFF_DSLP, 32'h50, r);
      mode(1'b1, 1'b0, 32'hf0);
      mode(1'b0, 1'b1, 32'hf0);
      wr(OFF_CTRL, 32'h1, r);
      mode(1'b1, 1'b0, 32'h30);
      mode(1'b0, 1'b1, 32'h50);
      mode(1'b0, 1'b0, 32'hf0);
      // Regulator failure action
      wr(OFF_CTRL, 32'h10, r);
      reg_unregulated <= 1'b1;
      idle(3);
      chk(reg_fail_rst, 1'b1);
      wr(OFF_CTRL, 32'h0, r);
      idle(3);
      chk(reg_fail_rst, 1'b0);
      @(posedge clk_sys);
      reg_unregulated <= 1'b0;
      // Internal oscillator stops under check
      wr(OFF_MASK, 32'h3, r);
      wr(OFF_CTRL, 32'h2, r);
      i_run <= 1'b0;
      for (int i = 0; i < 80 && irq !== 1'b1; i++)
         idle(1);
      chk(irq, 1'b1);
      wr(OFF_CTRL, 32'h0, r);
      i_run <= 1'b1;
      idle(10);
      chk(irq, 1'b1);
      rd(OFF_STAT, v, r);
      chk(v, 32'h1);
      rd(OFF_STAT, v, r);
      chk(v, 32'h0);
      chk(irq, 1'b0);
      // No check while an oscillator is off
      int_osc_on <= 1'b0;
      wr(OFF_CTRL, 32'h2, r);
      i_run <= 1'b0;
      idle(80);
      rd(OFF_STAT, v, r);
      chk(v, 32'h0);
      wr(OFF_CTRL, 32'h0, r);
      i_run <= 1'b1;
      int_osc_on <= 1'b1;
      // Main oscillator stops, source masked
      wr(OFF_MASK, 32'h1, r);
      wr(OFF_CTRL, 32'h8, r);
      m_run <= 1'b0;
      idle(80);
      chk(irq, 1'b0);
      rd(OFF_STAT, v, r);
      chk(v, 32'h2);
      wr(OFF_CTRL, 32'h0, r);
      m_run <= 1'b1;
      // Main check by its own enable, idle while one oscillator is off
      main_osc_on <= 1'b0;
      wr(OFF_CTRL, 32'h4, r);
      m_run <= 1'b0;
      idle(80);
      rd(OFF_STAT, v, r);
      chk(v, 32'h0);
      main_osc_on <= 1'b1;
      wr(OFF_MASK, 32'h3, r);
      for (int i = 0; i < 80 && irq !== 1'b1; i++)
         idle(1);
      chk(irq, 1'b1);
      wr(OFF_CTRL, 32'h0, r);
      m_run <= 1'b1;
      // Write of the other bit leaves it set; its own bit clears it
      wr(OFF_STAT, 32'h1, r);
      chk(irq, 1'b1);
      wr(OFF_STAT, 32'h2, r);
      chk(irq, 1'b0);
      conclude();
   end
endmodule

`default_nettype wire
